// File: logic/prog_port_regs.svh
`ifndef PROG_PORT_REGS_SVH
`define PROG_PORT_REGS_SVH

// ****************************************
// command codes and framing
// ****************************************
`define CMD_LOAD_CONFIG   6'h00
`define CMD_LOAD_DATA     6'h02
`define CMD_READ_DATA     6'h04
`define CMD_INC_ADDRESS   6'h06
`define CMD_BEGIN_PROGRAM 6'h08
`define CMD_END_PROGRAM   6'h0E
`define CMD_BITS          6
`define WORD_CYCLES       5'h10
`define WORD_FIRST_CYCLE  5'h02
`define WORD_LAST_BIT     5'h0F

// ****************************************
// storage layout and reset values
// ****************************************
`define WORD_WIDTH        14
`define ADDR_WIDTH        7
`define USER_DEPTH        128
`define CONFIG_DEPTH      8
`define CONFIG_WORD_INDEX 3'h7
`define ERASED_WORD       14'h3FFF
`define ADDR_RESET        7'h00
`define RESET_PIN_FUNCTION_ENABLE_BIT         2
`define OSC_MSB           1
`define OSC_LSB           0
`define LOG_DEPTH         32

`endif

// File: logic/prog_port_pkg.sv
`include "prog_port_regs.svh"

package prog_port_pkg;

   // ****************************************
   // link commands and states
   // ****************************************
   typedef enum logic [5:0] {
      CMD_LOAD_CONFIG   = 6'b000000,
      CMD_LOAD_DATA     = 6'b000010,
      CMD_READ_DATA     = 6'b000100,
      CMD_INC_ADDRESS   = 6'b000110,
      CMD_BEGIN_PROGRAM = 6'b001000,
      CMD_END_PROGRAM   = 6'b001110
   } cmd_type;

   typedef enum logic [1:0] {
      LINK_CMD  = 2'b00,
      LINK_LOAD = 2'b01,
      LINK_READ = 2'b10
   } link_state_type;

   // one programming event as seen by the write log
   typedef struct packed {
      logic                     config_space;
      logic [`ADDR_WIDTH-1:0]   address;
      logic [`WORD_WIDTH-1:0]   data;
   } log_rec_type;

endpackage

// File: logic/stream_fifo.sv
`timescale 1ns/1ps

module stream_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 32
) (
   input  wire logic             clock_in,     // system clock
   input  wire logic             reset_n_in,   // sync reset, low
   input  wire logic             in_valid_in,  // write request
   output logic                  in_ready_out, // space available
   input  wire logic [WIDTH-1:0] in_data_in,   // write data
   output logic                  out_valid_out,// data available
   input  wire logic             out_ready_in, // reader takes word
   output logic      [WIDTH-1:0] out_data_out  // head word
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   // honest flags straight from the fill count
   assign in_ready_out  = (count_q != (AW+1)'(DEPTH));
   assign out_valid_out = (count_q != '0);
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;
   assign out_data_out  = store_q[rd_ptr_q];

   // storage has no reset; only valid slots are ever read
   always_ff @(posedge clock_in) begin
      if (push) begin
         store_q[wr_ptr_q] <= in_data_in;
      end
   end

   // pointers wrap naturally since depth is a power of two
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         wr_ptr_q <= wr_ptr_q + AW'(push);
         rd_ptr_q <= rd_ptr_q + AW'(pop);
         count_q  <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule

// File: logic/eprom_serial_program_port.sv
`timescale 1ns/1ps

module eprom_serial_program_port
   import prog_port_pkg::*;
(
   input  wire logic        clock_in,                 // 50 MHz clock
   input  wire logic        reset_n_in,               // mode exit, low
   input  wire logic        program_clock_pin_in,     // link clock pin
   input  wire logic        program_data_pin_in,      // data pin level
   output logic             program_data_pin_out,     // data driven
   output logic             program_data_pin_oe_out,  // data pin drive
   input  wire logic        shared_pin_seven_in,      // pin seven level
   output logic             shared_pin_seven_reset_n_out, // reset via pin
   output logic             reset_pin_function_enable_out, // cfg bit 2
   output logic [1:0]       oscillator_select_out,    // cfg bits 1..0
   output logic             high_speed_crystal_out,   // osc is 11
   output logic             standard_crystal_out,     // osc is 01
   output logic             low_power_crystal_out,    // osc is 00
   output logic             config_space_out,         // pointer in cfg
   output logic [6:0]       address_out,              // pointer value
   output logic             programming_pulse_out,    // pulse active
   output logic             write_log_valid_out,      // log word ready
   input  wire logic        write_log_ready_in,       // log word taken
   output log_rec_type      write_log_data_out        // log word
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   localparam int NSYNC = 3;

   logic [NSYNC-1:0] pins_raw;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic             link_clk_prev_q;
   logic             link_clk;
   logic             link_data;
   logic             pin7_level;
   logic             link_rise;
   logic             link_fall;

   assign pins_raw = {shared_pin_seven_in, program_data_pin_in,
                      program_clock_pin_in};

   // two flops per pin; first stage feeds only the second
   generate
      for (genvar i = 0; i < NSYNC; i++) begin : g_sync
         always_ff @(posedge clock_in) begin
            if (!reset_n_in) begin
               sync1_q[i] <= 1'b0;
               sync2_q[i] <= 1'b0;
            end else begin
               sync1_q[i] <= pins_raw[i];
               sync2_q[i] <= sync1_q[i];
            end
         end
      end
   endgenerate

   assign link_clk   = sync2_q[0];
   assign link_data  = sync2_q[1];
   assign pin7_level = sync2_q[2];

   // edge finder on the resynchronised link clock
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         link_clk_prev_q <= 1'b0;
      end else begin
         link_clk_prev_q <= link_clk;
      end
   end

   assign link_rise = link_clk && !link_clk_prev_q;
   assign link_fall = !link_clk && link_clk_prev_q;

   // ****************************************
   // state and storage
   // ****************************************
   link_state_type           state_q;
   link_state_type           state_d;
   logic [4:0]               bit_cnt_q;
   logic [4:0]               bit_cnt_d;
   logic [5:0]               cmd_sr_q;
   logic [13:0]              shift_q;
   logic [13:0]              latch_q;
   logic [6:0]               addr_q;
   logic                     cfg_space_q;
   logic                     prog_active_q;
   logic                     prog_pending_q;
   logic                     data_out_q;
   logic                     data_oe_q;
   logic [13:0]              user_mem_q [`USER_DEPTH];
   logic [13:0]              cfg_mem_q  [`CONFIG_DEPTH];

   // addressed word, used by read-back and by the burn
   function automatic logic [13:0] fetch(input logic       space,
                                         input logic [6:0] a);
      logic [13:0] w;
      w = space ? cfg_mem_q[a[2:0]] : user_mem_q[a];
      return w;
   endfunction

   // ****************************************
   // command decode
   // ****************************************
   logic [5:0]  cmd_word;
   logic        cmd_done;
   logic        is_load_cfg;
   logic        is_load_data;
   logic        is_read;
   logic        is_inc;
   logic        is_begin;
   logic        is_end;
   logic        word_fall;
   logic        word_rise;
   logic        word_done;
   logic [4:0]  cycle_now;
   logic [13:0] addressed_word;
   logic        log_ready;
   logic        prog_fire;
   log_rec_type log_rec;

   assign cmd_word = {link_data, cmd_sr_q[5:1]};
   assign cmd_done = (state_q == LINK_CMD) && link_fall &&
                     (bit_cnt_q == 5'(`CMD_BITS - 1));

   assign is_load_cfg  = cmd_done && (cmd_word == `CMD_LOAD_CONFIG);
   assign is_load_data = cmd_done && (cmd_word == `CMD_LOAD_DATA);
   assign is_read      = cmd_done && (cmd_word == `CMD_READ_DATA);
   assign is_inc       = cmd_done && (cmd_word == `CMD_INC_ADDRESS);
   assign is_begin     = cmd_done && (cmd_word == `CMD_BEGIN_PROGRAM);
   assign is_end       = cmd_done && (cmd_word == `CMD_END_PROGRAM);

   // cycle number of a word frame, counted from one
   assign cycle_now = bit_cnt_q + 5'h01;
   assign word_fall = (state_q != LINK_CMD) && link_fall;
   assign word_rise = (state_q != LINK_CMD) && link_rise;
   assign word_done = word_fall && (cycle_now == `WORD_CYCLES);

   assign addressed_word = fetch(cfg_space_q, addr_q);

   // ****************************************
   // link sequencer
   // ****************************************
   // next state and bit counter
   always_comb begin
      state_d   = state_q;
      bit_cnt_d = bit_cnt_q;
      unique case (state_q)
         LINK_CMD: begin
            if (link_fall) begin
               bit_cnt_d = bit_cnt_q + 5'h01;
            end
            if (cmd_done) begin
               bit_cnt_d = '0;
               if (is_load_cfg || is_load_data) begin
                  state_d = LINK_LOAD;
               end else if (is_read) begin
                  state_d = LINK_READ;
               end
            end
         end
         LINK_LOAD, LINK_READ: begin
            if (link_fall) begin
               bit_cnt_d = cycle_now;
            end
            if (word_done) begin
               bit_cnt_d = '0;
               state_d   = LINK_CMD;
            end
         end
         default: begin
            state_d   = LINK_CMD;
            bit_cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         state_q   <= LINK_CMD;
         bit_cnt_q <= '0;
      end else begin
         state_q   <= state_d;
         bit_cnt_q <= bit_cnt_d;
      end
   end

   // command bits taken on falling edge
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         cmd_sr_q <= '0;
      end else if ((state_q == LINK_CMD) && link_fall) begin
         cmd_sr_q <= cmd_word;
      end
   end

   // ****************************************
   // transfer latch
   // ****************************************
   // payload shifts in LSb first
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         shift_q <= `ERASED_WORD;
      end else if ((state_q == LINK_LOAD) && word_fall &&
                   (cycle_now >= `WORD_FIRST_CYCLE) &&
                   (cycle_now <= `WORD_LAST_BIT)) begin
         shift_q <= {link_data, shift_q[13:1]};
      end
   end

   // latch loads on frame end (load) or on decode (read)
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         latch_q <= `ERASED_WORD;
      end else if (is_read) begin
         latch_q <= addressed_word;
      end else if ((state_q == LINK_LOAD) && word_done) begin
         latch_q <= shift_q;
      end else if ((state_q == LINK_READ) && word_rise &&
                   (cycle_now > `WORD_FIRST_CYCLE)) begin
         latch_q <= {1'b1, latch_q[13:1]};
      end
   end

   // ****************************************
   // read-back driver
   // ****************************************
   // drive from second rise, release after sixteenth
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         data_oe_q  <= 1'b0;
         data_out_q <= 1'b0;
      end else if (state_q == LINK_READ) begin
         if (word_rise && (cycle_now == `WORD_FIRST_CYCLE)) begin
            // bit 0 from second rising edge
            data_oe_q  <= 1'b1;
            data_out_q <= latch_q[0];
         end else if (word_rise && (cycle_now <= `WORD_LAST_BIT)) begin
            data_out_q <= latch_q[1];
         end else if (word_rise) begin
            data_out_q <= 1'b0;
         end
         if (word_done) begin
            data_oe_q <= 1'b0;
         end
      end else begin
         data_oe_q  <= 1'b0;
         data_out_q <= 1'b0;
      end
   end

   assign program_data_pin_out    = data_out_q;
   assign program_data_pin_oe_out = data_oe_q;

   // ****************************************
   // address pointer
   // ****************************************
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         addr_q      <= `ADDR_RESET;
         cfg_space_q <= 1'b0;
      end else if (is_load_cfg && !cfg_space_q) begin
         // enter configuration space at its base
         cfg_space_q <= 1'b1;
         addr_q      <= `ADDR_RESET;
      end else if (is_inc) begin
         addr_q <= addr_q + 7'h01;
      end
   end

   assign config_space_out = cfg_space_q;
   assign address_out      = addr_q;

   // ****************************************
   // programming pulse
   // ****************************************
   // a begin waits while the log is full, so no burn goes unlogged
   assign prog_fire = (is_begin || prog_pending_q) && log_ready &&
                      !is_end;

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         prog_active_q  <= 1'b0;
         prog_pending_q <= 1'b0;
      end else if (is_end) begin
         // end stops any pulse, pending or running
         prog_active_q  <= 1'b0;
         prog_pending_q <= 1'b0;
      end else if (prog_fire) begin
         prog_active_q  <= 1'b1;
         prog_pending_q <= 1'b0;
      end else if (is_begin) begin
         prog_pending_q <= 1'b1;
      end
   end

   assign programming_pulse_out = prog_active_q;

   // ****************************************
   // cell arrays
   // ****************************************
   // burning only clears bits; zeros stay zeros
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < `USER_DEPTH; i++) begin
            user_mem_q[i] <= `ERASED_WORD;
         end
         for (int j = 0; j < `CONFIG_DEPTH; j++) begin
            cfg_mem_q[j] <= `ERASED_WORD;
         end
      end else if (prog_fire) begin
         if (cfg_space_q) begin
            cfg_mem_q[addr_q[2:0]] <= addressed_word & latch_q;
         end else begin
            user_mem_q[addr_q] <= addressed_word & latch_q;
         end
      end
   end

   // ****************************************
   // write log
   // ****************************************
   assign log_rec.config_space = cfg_space_q;
   assign log_rec.address      = addr_q;
   assign log_rec.data         = latch_q;

   stream_fifo #(
      .WIDTH ($bits(log_rec_type)),
      .DEPTH (`LOG_DEPTH)
   ) u_log_fifo (
      .clock_in      (clock_in),
      .reset_n_in    (reset_n_in),
      .in_valid_in   (prog_fire),
      .in_ready_out  (log_ready),
      .in_data_in    (log_rec),
      .out_valid_out (write_log_valid_out),
      .out_ready_in  (write_log_ready_in),
      .out_data_out  (write_log_data_out)
   );

   // ****************************************
   // configuration word decode
   // ****************************************
   logic [13:0] cfg_word;
   logic [1:0]  osc_bits;

   assign cfg_word = cfg_mem_q[`CONFIG_WORD_INDEX];
   assign osc_bits = cfg_word[`OSC_MSB:`OSC_LSB];

   // bit 2 hands pin seven the reset role
   assign reset_pin_function_enable_out = cfg_word[`RESET_PIN_FUNCTION_ENABLE_BIT];
   assign shared_pin_seven_reset_n_out  =
      cfg_word[`RESET_PIN_FUNCTION_ENABLE_BIT] ? pin7_level : 1'b1;

   assign oscillator_select_out  = osc_bits;
   assign high_speed_crystal_out = (osc_bits == 2'h3);
   assign standard_crystal_out   = (osc_bits == 2'h1);
   assign low_power_crystal_out  = (osc_bits == 2'h0);

endmodule

// File: tb/prog_port_assertions.sv
`timescale 1ns/1ps

module prog_port_assertions (
   input wire logic       clock_in,                      // clock
   input wire logic       reset_n_in,                    // sync reset
   input wire logic       program_clock_pin_in,          // link clock
   input wire logic       program_data_pin_out,          // read bit
   input wire logic       program_data_pin_oe_out,       // pin drive
   input wire logic       shared_pin_seven_in,           // pin seven
   input wire logic       shared_pin_seven_reset_n_out,  // pin reset
   input wire logic       reset_pin_function_enable_out, // cfg bit 2
   input wire logic [1:0] oscillator_select_out,         // cfg 1..0
   input wire logic       high_speed_crystal_out,        // osc 11
   input wire logic       standard_crystal_out,          // osc 01
   input wire logic       low_power_crystal_out,         // osc 00
   input wire logic       config_space_out,              // cfg space
   input wire logic [6:0] address_out,                   // pointer
   input wire logic       programming_pulse_out,         // burn pulse
   input wire logic       write_log_valid_out            // log head
);
   // ****************************************
   // port relations
   // ****************************************
   default clocking dflt @(posedge clock_in);
   endclocking
   default disable iff (!reset_n_in);

   // pin seven must sit still across the synchroniser
   sequence pin7_steady;
      $stable(shared_pin_seven_in) [*3];
   endsequence

   AST_OSC_DECODE: assert property (
      {high_speed_crystal_out, standard_crystal_out, low_power_crystal_out}
      == {oscillator_select_out == 2'b11, oscillator_select_out == 2'b01,
          oscillator_select_out == 2'b00})
      else $error("crystal flags disagree with oscillator select");
   AST_PIN7_FOLLOW: assert property (
      $past(reset_n_in, 3) ##0 pin7_steady ##0 reset_pin_function_enable_out
      |-> shared_pin_seven_reset_n_out == shared_pin_seven_in)
      else $error("pin seven reset does not follow the pin");
   AST_PIN7_GPIO: assert property (
      !reset_pin_function_enable_out |-> shared_pin_seven_reset_n_out)
      else $error("pin seven resets while used as plain io");
   AST_RESET_STATE: assert property (
      $rose(reset_n_in) |-> address_out == 7'h00 && !config_space_out
      && !programming_pulse_out && !program_data_pin_oe_out)
      else $error("state after reset is not idle at location zero");
   AST_CFG_STICKY: assert property (
      config_space_out |=> config_space_out)
      else $error("pointer left configuration space without reset");
   AST_ADDR_STEP: assert property (
      $changed(address_out) |-> address_out == 7'($past(address_out) + 7'h01)
      || ($rose(config_space_out) && address_out == 7'h00))
      else $error("pointer moved by other than one");
   AST_ADDR_ON_FALL: assert property (
      $changed(address_out) |-> !$past(program_clock_pin_in, 2))
      else $error("pointer moved away from a link falling edge");
   AST_OE_RISE: assert property (
      $rose(program_data_pin_oe_out) |-> $past(program_clock_pin_in, 2))
      else $error("data pin drive began away from a rising edge");
   AST_OE_FALL: assert property (
      $fell(program_data_pin_oe_out) |-> !$past(program_clock_pin_in, 2))
      else $error("data pin released away from a falling edge");
   AST_DATA_ON_RISE: assert property (
      program_data_pin_oe_out && $changed(program_data_pin_out)
      |-> $past(program_clock_pin_in, 2))
      else $error("read bit changed away from a rising edge");
   AST_PULSE_END: assert property (
      $fell(programming_pulse_out) |-> !$past(program_clock_pin_in, 2))
      else $error("burn pulse ended without a command edge");
   AST_PULSE_LOGGED: assert property (
      $rose(programming_pulse_out) |-> ##[0:2] write_log_valid_out)
      else $error("burn pulse left no log record");
endmodule

bind eprom_serial_program_port prog_port_assertions u_prog_port_assertions (.*);

// File: tb/programmer_model.sv
`timescale 1ns/1ps

module programmer_model (
   input  wire logic clock_in,       // system clock
   input  wire logic dev_data_in,    // device read bit
   input  wire logic dev_oe_in,      // device drives pin
   output logic      link_clock_out, // link clock pin
   output logic      pin_level_out   // resolved data pin
);
   // ****************************************
   // serial programmer
   // ****************************************
   logic drive_q; // programmer drives the pin
   logic bit_q;   // value it drives
   logic idle_q;  // undriven wire has no pull: show a changing level

   initial begin
      drive_q = 1'b0;
      bit_q = 1'b0;
      idle_q = 1'b0;
      link_clock_out = 1'b0;
   end

   always @(posedge clock_in) idle_q <= ~idle_q;
   assign pin_level_out = dev_oe_in ? dev_data_in : (drive_q ? bit_q : idle_q);

   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask

   // bit set at the rise, held well past the sampling fall
   task automatic link_cycle(input logic drive, input logic b);
      link_clock_out <= 1'b1;
      drive_q <= drive;
      bit_q <= b;
      tick(4);
      link_clock_out <= 1'b0;
      tick(4);
   endtask

   // six cycles low bit first; link clock then idles low
   task automatic send_cmd(input logic [5:0] code);
      for (int i = 0; i < 6; i++) link_cycle(1'b1, code[i]);
      drive_q <= 1'b0;
      tick(8);
   endtask

   // start, fourteen bits low first, stop; pin released on read
   task automatic frame(input logic rd, input logic [13:0] w,
                        output logic [13:0] r);
      r = 14'h0000;
      for (int c = 1; c <= 16; c++) begin
         link_cycle(!rd, (c >= 2 && c <= 15) ? w[c-2] : 1'b0);
         if (c >= 2 && c <= 15) r[c-2] = pin_level_out;
      end
      drive_q <= 1'b0;
      tick(8);
   endtask
endmodule

// File: tb/tb_eprom_serial_program_port.sv
`timescale 1ns/1ps

module tb_eprom_serial_program_port
   import prog_port_pkg::*;
;
   // ****************************************
   // bench
   // ****************************************
   typedef struct packed {
      logic        rst;  // reset before the row
      logic        cfg;  // word goes to configuration space
      logic [4:0]  incs; // increments
      logic [13:0] word; // loaded word, upper cfg bits ones
      logic [6:0]  addr; // pointer expected
      logic [13:0] rd;   // read back expected
   } row_type;

   // configuration words keep bits 13..3 at one
   row_type rows [6] = '{
      '{1'b0, 1'b0, 5'h10, 14'h1234, 7'h10, 14'h1234},
      '{1'b0, 1'b0, 5'h00, 14'h3FF0, 7'h10, 14'h1230},
      '{1'b0, 1'b0, 5'h01, 14'h2AAA, 7'h11, 14'h2AAA},
      '{1'b1, 1'b1, 5'h07, 14'h3FFE, 7'h07, 14'h3FFE},
      '{1'b1, 1'b1, 5'h07, 14'h3FFD, 7'h07, 14'h3FFD},
      '{1'b0, 1'b1, 5'h00, 14'h3FF8, 7'h07, 14'h3FF8}};
   logic [5:0]  junk [3] = '{6'h3F, 6'h01, 6'h0A};
   logic        clock_in, reset_n_in, link_clk, pin_level, dev_data, dev_oe;
   logic        pin7_in, pin7_rst_n, reset_pin_function_enable, hs, xt, lp, cfg_sp, pulse;
   logic        log_valid, log_ready;
   logic [1:0]  osc;
   logic [6:0]  addr;
   logic [13:0] rd;
   log_rec_type log_data;
   int          bad_count = 0, check_count = 0, cycles = 0, pops = 0;
   logic [15:0] sum = 16'h0000;

   eprom_serial_program_port u_eprom_serial_program_port (
      .clock_in(clock_in), .reset_n_in(reset_n_in),
      .program_clock_pin_in(link_clk), .program_data_pin_in(pin_level),
      .program_data_pin_out(dev_data), .program_data_pin_oe_out(dev_oe),
      .shared_pin_seven_in(pin7_in), .shared_pin_seven_reset_n_out(pin7_rst_n),
      .reset_pin_function_enable_out(reset_pin_function_enable), .oscillator_select_out(osc),
      .high_speed_crystal_out(hs), .standard_crystal_out(xt),
      .low_power_crystal_out(lp), .config_space_out(cfg_sp),
      .address_out(addr), .programming_pulse_out(pulse),
      .write_log_valid_out(log_valid), .write_log_ready_in(log_ready),
      .write_log_data_out(log_data));

   programmer_model u_programmer_model (
      .clock_in(clock_in), .dev_data_in(dev_data), .dev_oe_in(dev_oe),
      .link_clock_out(link_clk), .pin_level_out(pin_level));

   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end

   // hang guard, about twice the expected run
   always @(posedge clock_in) begin
      cycles++;
      if (log_valid === 1'b1 && log_ready === 1'b1) pops++;
      if (cycles == 60000) begin
         bad_count++;
         $display("unexpected timeout expected finish seen hang");
         results();
      end
   end

   task automatic check(input string what, input logic [13:0] seen,
                        input logic [13:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic do_reset();
      reset_n_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      reset_n_in <= 1'b1;
      @(posedge clock_in);
   endtask

   // erased cells read as ones
   task automatic check_reset();
      check("address", addr, 7'h00);
      check("config space", cfg_sp, 1'b0);
      check("oscillator", osc, 2'b11);
      check("pin7 enable", reset_pin_function_enable, 1'b1);
      check("data oe", dev_oe, 1'b0);
   endtask

   task automatic burn();
      u_programmer_model.send_cmd(CMD_BEGIN_PROGRAM);
      check("pulse on", pulse, 1'b1);
      u_programmer_model.send_cmd(CMD_END_PROGRAM);
      check("pulse off", pulse, 1'b0);
   endtask

   initial begin
      reset_n_in = 1'b0;
      pin7_in = 1'b0;
      log_ready = 1'b0;
      do_reset();
      check_reset();
      $display("reset test done");
      foreach (rows[i]) begin
         pin7_in <= rows[i].word[1];
         if (rows[i].rst) do_reset();
         if (rows[i].cfg) begin
            u_programmer_model.send_cmd(CMD_LOAD_CONFIG);
            u_programmer_model.frame(1'b0, rows[i].word, rd);
         end
         repeat (rows[i].incs) u_programmer_model.send_cmd(CMD_INC_ADDRESS);
         if (!rows[i].cfg) begin
            u_programmer_model.send_cmd(CMD_LOAD_DATA);
            u_programmer_model.frame(1'b0, rows[i].word, rd);
         end
         check("address", addr, rows[i].addr);
         check("config space", cfg_sp, rows[i].cfg);
         burn();
         u_programmer_model.send_cmd(CMD_READ_DATA);
         u_programmer_model.frame(1'b1, 14'h0000, rd);
         if (rows[i].cfg) begin
            check("config bits", rd[2:0], rows[i].rd[2:0]);
            check("pin7 enable", reset_pin_function_enable, rows[i].rd[2]);
            check("pin7 reset", pin7_rst_n,
                  rows[i].rd[2] ? rows[i].word[1] : 1'b1);
            check("oscillator", osc, rows[i].rd[1:0]);
            check("crystal", {hs, xt, lp}, {rows[i].rd[1:0] == 2'b11,
               rows[i].rd[1:0] == 2'b01, rows[i].rd[1:0] == 2'b00});
         end
         else check("read word", rd, rows[i].rd);
         repeat (3) burn();
         $display("row %0d done", i);
      end
      foreach (junk[k]) u_programmer_model.send_cmd(junk[k]);
      check("address", addr, 7'h07);
      check("pulse", pulse, 1'b0);
      u_programmer_model.send_cmd(CMD_READ_DATA);
      u_programmer_model.frame(1'b1, 14'h0000, rd);
      check("config bits", rd[2:0], 3'h0);
      $display("unknown command test done");
      // eight records held; 24 more fill the log, the next begin waits
      repeat (24) burn();
      check("log head", {log_data.config_space, log_data.address},
            8'h87);
      u_programmer_model.send_cmd(CMD_BEGIN_PROGRAM);
      check("pulse held", pulse, 1'b0);
      log_ready <= 1'b1;
      for (int n = 0; n < 20 && pulse !== 1'b1; n++) @(posedge clock_in);
      check("pulse late", pulse, 1'b1);
      u_programmer_model.send_cmd(CMD_END_PROGRAM);
      check("pulse off", pulse, 1'b0);
      for (int n = 0; n < 60 && log_valid !== 1'b0; n++) @(posedge clock_in);
      check("log pops", 14'(pops), 14'h0021);
      $display("log fill test done");
      do_reset();
      check_reset();
      // skip the offset, sum user words, negate
      repeat (16) u_programmer_model.send_cmd(CMD_INC_ADDRESS);
      for (int a = 0; a < 69; a++) begin
         u_programmer_model.send_cmd(CMD_READ_DATA);
         u_programmer_model.frame(1'b1, 14'h0000, rd);
         sum += rd;
         u_programmer_model.send_cmd(CMD_INC_ADDRESS);
      end
      check("checksum", 8'(-sum), 8'h45);
      $display("final reset test done");
      results();
   end
endmodule
